// ==== hw/lane_ddc_overrange_config.sv ====
// Configuration bank for link-B extra lanes, sync header, DDC gain and over-range tags
//
// Function
// - extra-serializer bit also enables extra serializers
// - extra lanes follow link mode and pattern
// - extra-only lanes send ramp for pattern 0/5
// - channel power-down overrides all extra lanes
// - serializer n needs lanes 0..n-1 enabled
// - sync header field selects CRC-12 or FEC
// - 32 data bits; ignored in 8b/10b
// - all sync-word command fields driven zero
// - gain boost selects 0 or 6.02 dB
// - in-phase tag set at threshold zero
// - quadrature tag set at threshold one
// - threshold scale has full scale 256
`timescale 1ns/1ns
module lane_ddc_overrange_config
	import lane_ddc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Link settings from neighbouring registers
	input wire logic serial_link_enable,
	input wire logic link_is_64b66b,
	input wire logic [LANES-1:0] link_mode_lanes,
	input wire logic [TEST_W-1:0] link_test_pattern,
	input wire logic channel_power_down,
	// Lane controls toward link B
	output logic [LANES-1:0] lane_clk_en,
	output logic [LANES-1:0] serializer_en,
	output logic [LANES-1:0][TEST_W-1:0] lane_pattern,
	// Sync header and gain controls
	output sync_ctrl_type sync_ctrl,
	output logic gain_boost,
	// DDC sample streams
	input wire sample_type ddc_i_in,
	input wire sample_type ddc_q_in,
	output tagged_sample_type ddc_i_out,
	output tagged_sample_type ddc_q_out,
	// Interrupt
	output logic irq
);

	initial begin
		if (ADDR_W < ADDR_W_MIN) begin
			$error("lane_ddc_overrange_config: address too narrow");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode

	logic [7:0] extra_lane_r;
	logic [7:0] sync_header_r;
	logic [7:0] gain_cfg_r;
	logic [7:0] thr_i_r;
	logic [7:0] thr_q_r;
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] irq_status_nxt;
	logic [9:0] index;
	logic aligned;
	logic mapped;
	logic wr_fire;
	logic wr_lane0;
	logic [7:0] wbyte;
	logic [7:0] rd_val;
	logic [LANES-1:0] lane_on;
	logic [LANES-1:0] ser_on;
	logic cfg_write_live;

	always_comb begin
		index = paddr[11:2];
		aligned = (paddr[1:0] == 2'b00) && ((paddr >> ADDR_W_MIN) == '0);
		unique case (index)
			IDX_EXTRA_LANE_B,
			IDX_SYNC_HEADER,
			IDX_GAIN_CFG,
			IDX_THR_INPHASE,
			IDX_THR_QUAD,
			IDX_IRQ_STATUS,
			IDX_IRQ_MASK,
			IDX_LANE_STATUS: mapped = aligned;
			default: mapped = 1'b0;
		endcase
	end

	// Zero wait states: read data is latched in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_fire = psel && penable && pwrite && mapped;
	assign wr_lane0 = wr_fire && pstrb[0];
	assign wbyte = pwdata[7:0];

	always_comb begin
		unique case (index)
			IDX_EXTRA_LANE_B: rd_val = extra_lane_r;
			IDX_SYNC_HEADER: rd_val = sync_header_r;
			IDX_GAIN_CFG: rd_val = gain_cfg_r;
			IDX_THR_INPHASE: rd_val = thr_i_r;
			IDX_THR_QUAD: rd_val = thr_q_r;
			IDX_IRQ_STATUS: rd_val = {5'h00, irq_status_r};
			IDX_IRQ_MASK: rd_val = {5'h00, irq_mask_r};
			IDX_LANE_STATUS: rd_val = lane_clk_en;
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= (mapped && !pwrite) ? {24'h000000, rd_val} : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	// Extra-lane and sync header writes while the link runs are taken but reported, the hazard is software's
	assign cfg_write_live = wr_lane0 && serial_link_enable &&
		(index == IDX_EXTRA_LANE_B || index == IDX_SYNC_HEADER);

	always_ff @(posedge clk) begin
		if (rst) begin
			extra_lane_r <= RST_EXTRA_LANE_B;
		end else if (wr_lane0 && index == IDX_EXTRA_LANE_B) begin
			extra_lane_r <= wbyte;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_header_r <= RST_SYNC_HEADER;
		end else if (wr_lane0 && index == IDX_SYNC_HEADER) begin
			sync_header_r <= {6'h00, wbyte[1:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gain_cfg_r <= RST_GAIN_CFG;
		end else if (wr_lane0 && index == IDX_GAIN_CFG) begin
			gain_cfg_r <= {7'h00, wbyte[GAIN_BOOST_BIT]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			thr_i_r <= RST_THR_INPHASE;
		end else if (wr_lane0 && index == IDX_THR_INPHASE) begin
			thr_i_r <= wbyte;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			thr_q_r <= RST_THR_QUAD;
		end else if (wr_lane0 && index == IDX_THR_QUAD) begin
			thr_q_r <= wbyte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lane enables

	// Lane 0 is never extra; it comes only from the link mode
	always_comb begin
		lane_on = link_mode_lanes | {extra_lane_r[7:EXTRA_LANE_LSB], 1'b0};
		if (channel_power_down) begin
			lane_on = '0;
		end
	end

	genvar n;
	generate
		for (n = 0; n < LANES; n++) begin : g_lane
			logic ser_req;
			logic lower_ok;
			logic extra_only;
			// Extra-only lanes get clocks; serializer needs the extra-serializer bit
			assign extra_only = lane_on[n] && !link_mode_lanes[n];
			assign ser_req = lane_on[n] &&
				(link_mode_lanes[n] || extra_lane_r[EXTRA_SER_BIT]);
			if (n == 0) begin : g_first
				assign lower_ok = 1'b1;
			end else begin : g_rest
				assign lower_ok = &lane_on[n-1:0];
			end
			assign ser_on[n] = ser_req && lower_ok;

			always_ff @(posedge clk) begin
				if (rst) begin
					lane_pattern[n] <= TEST_NONE;
				end else if (extra_only &&
					(link_test_pattern == TEST_NONE || link_test_pattern == TEST_FIVE)) begin
					lane_pattern[n] <= TEST_RAMP;
				end else begin
					lane_pattern[n] <= link_test_pattern;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			lane_clk_en <= '0;
			serializer_en <= '0;
		end else begin
			lane_clk_en <= lane_on;
			serializer_en <= ser_on;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync header and gain

	sync_header_type sh_sel;
	assign sh_sel = sync_header_type'(sync_header_r[1:0]);

	// Reserved codes fall back to CRC-12 so the framer never sees an odd mix
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_ctrl <= '0;
		end else begin
			sync_ctrl.cmd <= '0;
			if (!link_is_64b66b) begin
				sync_ctrl.crc12_en <= 1'b0;
				sync_ctrl.fec_en <= 1'b0;
			end else begin
				unique case (sh_sel)
					SH_FEC: begin
						sync_ctrl.crc12_en <= 1'b0;
						sync_ctrl.fec_en <= 1'b1;
					end
					SH_CRC12,
					SH_RSVD1,
					SH_RSVD3: begin
						sync_ctrl.crc12_en <= 1'b1;
						sync_ctrl.fec_en <= 1'b0;
					end
				endcase
			end
		end
	end

	// No clip guard here; boost with an unfiltered image may saturate
	always_ff @(posedge clk) begin
		if (rst) begin
			gain_boost <= 1'b0;
		end else begin
			gain_boost <= gain_cfg_r[GAIN_BOOST_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Over-range tagging

	overrange_detect #(
		.WIDTH(SAMPLE_W)
	) u_ovr_i (
		.clk(clk),
		.rst(rst),
		.threshold(thr_i_r),
		.sample_in(ddc_i_in),
		.sample_out(ddc_i_out)
	);

	overrange_detect #(
		.WIDTH(SAMPLE_W)
	) u_ovr_q (
		.clk(clk),
		.rst(rst),
		.threshold(thr_q_r),
		.sample_in(ddc_q_in),
		.sample_out(ddc_q_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupts

	// A new event in the clearing cycle survives the clear
	always_comb begin
		irq_status_nxt = irq_status_r;
		if (wr_lane0 && index == IDX_IRQ_STATUS) begin
			irq_status_nxt = irq_status_r & ~wbyte[IRQ_W-1:0];
		end
		if (ddc_i_out.valid && ddc_i_out.ctrl) begin
			irq_status_nxt[IRQ_OVR_I_BIT] = 1'b1;
		end
		if (ddc_q_out.valid && ddc_q_out.ctrl) begin
			irq_status_nxt[IRQ_OVR_Q_BIT] = 1'b1;
		end
		if (cfg_write_live) begin
			irq_status_nxt[IRQ_LIVE_WR_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_status_r <= RST_IRQ;
		end else begin
			irq_status_r <= irq_status_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask_r <= RST_IRQ;
		end else if (wr_lane0 && index == IDX_IRQ_MASK) begin
			irq_mask_r <= wbyte[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_nxt & irq_mask_r);
		end
	end

endmodule : lane_ddc_overrange_config

// ==== hw/lane_ddc_pkg.sv ====
// Constants, field layouts and carrier types of the lane, DDC and over-range configuration bank
package lane_ddc_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [9:0] IDX_EXTRA_LANE_B = 10'h20B;
	localparam logic [9:0] IDX_SYNC_HEADER = 10'h20F;
	localparam logic [9:0] IDX_GAIN_CFG = 10'h210;
	localparam logic [9:0] IDX_THR_INPHASE = 10'h211;
	localparam logic [9:0] IDX_THR_QUAD = 10'h212;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h220;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h221;
	localparam logic [9:0] IDX_LANE_STATUS = 10'h222;
	localparam int ADDR_W_MIN = 12;

	// Values after reset
	localparam logic [7:0] RST_EXTRA_LANE_B = 8'h00;
	localparam logic [7:0] RST_SYNC_HEADER = 8'h00;
	localparam logic [7:0] RST_GAIN_CFG = 8'h00;
	localparam logic [7:0] RST_THR_INPHASE = 8'hF2;
	localparam logic [7:0] RST_THR_QUAD = 8'hAB;
	localparam logic [2:0] RST_IRQ = 3'h0;

	// Field positions
	localparam int EXTRA_SER_BIT = 0;
	localparam int EXTRA_LANE_LSB = 1;
	localparam int GAIN_BOOST_BIT = 0;
	localparam int IRQ_OVR_I_BIT = 0;
	localparam int IRQ_OVR_Q_BIT = 1;
	localparam int IRQ_LIVE_WR_BIT = 2;
	localparam int IRQ_W = 3;

	// Link geometry and test patterns
	localparam int LANES = 8;
	localparam int TEST_W = 4;
	localparam logic [3:0] TEST_NONE = 4'h0;
	localparam logic [3:0] TEST_RAMP = 4'h4;
	localparam logic [3:0] TEST_FIVE = 4'h5;
	localparam int SYNC_DATA_BITS = 32;
	localparam int SYNC_CMD_W = 19;
	localparam int SAMPLE_W = 16;
	localparam int THR_W = 8;

	typedef enum logic [1:0] {
		SH_CRC12 = 2'b00,
		SH_RSVD1 = 2'b01,
		SH_FEC = 2'b10,
		SH_RSVD3 = 2'b11
	} sync_header_type;

	// Per-sample stream carrier
	typedef struct packed {
		logic valid;
		logic signed [SAMPLE_W-1:0] data;
	} sample_type;

	typedef struct packed {
		logic valid;
		logic ctrl;
		logic signed [SAMPLE_W-1:0] data;
	} tagged_sample_type;

	// Sync-word controls toward the 64b/66b framer
	typedef struct packed {
		logic crc12_en;
		logic fec_en;
		logic [SYNC_CMD_W-1:0] cmd;
	} sync_ctrl_type;

endpackage : lane_ddc_pkg

// ==== hw/overrange_detect.sv ====
// Over-range tagging of one DDC output sample stream
`timescale 1ns/1ns
module overrange_detect
	import lane_ddc_pkg::*;
#(
	parameter int WIDTH = SAMPLE_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Threshold from the register bank
	input wire logic [THR_W-1:0] threshold,
	// Sample stream
	input wire sample_type sample_in,
	output tagged_sample_type sample_out
);

	initial begin
		if (WIDTH != SAMPLE_W || WIDTH < THR_W + 2) begin
			$error("overrange_detect: unsupported sample width");
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [WIDTH-1:0] mag;
	logic [THR_W:0] level;

	// Most negative code gives full-scale 256, so the level keeps nine bits
	always_comb begin
		mag = sample_in.data[WIDTH-1] ? WIDTH'(-sample_in.data) : WIDTH'(sample_in.data);
		level = mag[WIDTH-1 -: THR_W+1];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sample_out <= '0;
		end else begin
			sample_out.valid <= sample_in.valid;
			sample_out.data <= sample_in.data;
			sample_out.ctrl <= sample_in.valid && (level >= {1'b0, threshold});
		end
	end

endmodule : overrange_detect

// ==== test/lane_ddc_chk.sv ====
// Port assertions for the lane, sync header and over-range bank
`timescale 1ns/1ns
module lane_ddc_chk
	import lane_ddc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link settings and lane controls
	input wire logic link_is_64b66b,
	input wire logic [LANES-1:0] link_mode_lanes,
	input wire logic channel_power_down,
	input wire logic [LANES-1:0] lane_clk_en,
	input wire logic [LANES-1:0] serializer_en,
	input wire sync_ctrl_type sync_ctrl,
	// Sample streams
	input wire sample_type ddc_i_in,
	input wire sample_type ddc_q_in,
	input wire tagged_sample_type ddc_i_out,
	input wire tagged_sample_type ddc_q_out
);
	default clocking dclk @(posedge clk);
	endclocking
	default disable iff (rst);
	logic [LANES-1:0] low_run;
	// Unbroken run of running lanes from lane 0
	assign low_run = (~lane_clk_en & (lane_clk_en + 8'h01)) - 8'h01;
	sequence s_i_pass;
		ddc_i_out.valid && ddc_i_out.data == $past(ddc_i_in.data);
	endsequence
	////////////////////////////////
	a_pd_lanes_off: assert property (channel_power_down |=> lane_clk_en == '0)
		else $error("lanes run in power-down");
	a_mode_lanes_on: assert property (!channel_power_down |=>
		(lane_clk_en & $past(link_mode_lanes)) == $past(link_mode_lanes))
		else $error("mode lane stopped");
	a_ser_lower_on: assert property ((serializer_en & ~low_run) == '0)
		else $error("serializer without lower lanes");
	a_cmd_idle: assert property (sync_ctrl.cmd == '0)
		else $error("sync command not idle");
	a_sync_8b10b: assert property (!link_is_64b66b |=> !(sync_ctrl.crc12_en || sync_ctrl.fec_en))
		else $error("sync header active in 8b10b");
	a_sync_one_kind: assert property (link_is_64b66b |=> sync_ctrl.crc12_en ^ sync_ctrl.fec_en)
		else $error("sync header kind not single");
	a_i_latency: assert property (ddc_i_in.valid |=> s_i_pass)
		else $error("inphase sample lost");
	a_q_no_tag: assert property (!ddc_q_in.valid |=> !ddc_q_out.valid && !ddc_q_out.ctrl)
		else $error("quad tag without sample");
	a_full_scale: assert property (ddc_i_in.valid && ddc_i_in.data == 16'h8000 |=> ddc_i_out.ctrl)
		else $error("full scale not tagged");
endmodule : lane_ddc_chk

bind lane_ddc_overrange_config lane_ddc_chk u_chk (.clk(clk), .rst(rst),
	.link_is_64b66b(link_is_64b66b), .link_mode_lanes(link_mode_lanes),
	.channel_power_down(channel_power_down), .lane_clk_en(lane_clk_en),
	.serializer_en(serializer_en), .sync_ctrl(sync_ctrl), .ddc_i_in(ddc_i_in),
	.ddc_q_in(ddc_q_in), .ddc_i_out(ddc_i_out), .ddc_q_out(ddc_q_out));

// ==== test/link_rx_model.sv ====
// Far-side receiver model counting tagged samples
`timescale 1ns/1ns
module link_rx_model
	import lane_ddc_pkg::*;
(
	// Clock and received streams
	input wire logic clk,
	input wire tagged_sample_type i_in,
	input wire tagged_sample_type q_in,
	// Tag counts
	output int i_tags,
	output int q_tags
);
	initial i_tags = 0;
	initial q_tags = 0;
	always @(posedge clk) begin
		if (i_in.valid && i_in.ctrl) i_tags <= i_tags + 1;
		if (q_in.valid && q_in.ctrl) q_tags <= q_tags + 1;
	end
endmodule : link_rx_model

// ==== test/tb_top.sv ====
// Self-checking bench of the lane, sync, gain and over-range bank
`timescale 1ns/1ns
module tb_top
	import lane_ddc_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, gain_boost, er;
	// Link kept disabled during setting changes, except for the one live sync header write
	logic sle = 1'b0, l64 = 1'b0, cpd = 1'b0;
	logic [7:0] lml = 8'h00, lane_clk_en, serializer_en;
	logic [3:0] ltp = 4'h0;
	logic [LANES-1:0][TEST_W-1:0] lane_pattern, e_pat;
	sync_ctrl_type sync_ctrl;
	sample_type ddc_i_in = '0, ddc_q_in = '0;
	tagged_sample_type ddc_i_out, ddc_q_out, xi, xq;
	int mismatches = 0, samples_checked = 0, cyc = 0, ei = 0, eq = 0, i_tags, q_tags;
	int seed = 32'h54F34E52;

	lane_ddc_overrange_config DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .serial_link_enable(sle), .link_is_64b66b(l64),
		.link_mode_lanes(lml), .link_test_pattern(ltp), .channel_power_down(cpd),
		.lane_clk_en(lane_clk_en), .serializer_en(serializer_en), .lane_pattern(lane_pattern),
		.sync_ctrl(sync_ctrl), .gain_boost(gain_boost), .ddc_i_in(ddc_i_in),
		.ddc_q_in(ddc_q_in), .ddc_i_out(ddc_i_out), .ddc_q_out(ddc_q_out), .irq(irq));
	link_rx_model rx (.clk(clk), .i_in(ddc_i_out), .q_in(ddc_q_out), .i_tags(i_tags),
		.q_tags(q_tags));

	always #25 clk = ~clk;
	////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Registered outputs need one edge after the register update
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic irq_is(input logic e);
		settle();
		chk("irq", {31'h0, irq}, {31'h0, e});
	endtask : irq_is

	function automatic logic tag(input logic v, input logic signed [15:0] d, input logic [7:0] t);
		int m;
		m = (d < 0) ? -int'(d) : int'(d);
		return v && (m >> 7) >= t;
	endfunction : tag
	////////////////////////////////
	initial begin
		logic [7:0] ext, ti, tq, v, on, ser, rt[5], keep[5];
		logic [9:0] idx[5];
		logic signed [15:0] d, q;
		logic rr, pv;
		idx = '{IDX_EXTRA_LANE_B, IDX_SYNC_HEADER, IDX_GAIN_CFG, IDX_THR_INPHASE, IDX_THR_QUAD};
		rt = '{RST_EXTRA_LANE_B, RST_SYNC_HEADER, RST_GAIN_CFG, RST_THR_INPHASE, RST_THR_QUAD};
		keep = '{8'hFF, 8'h03, 8'h01, 8'hFF, 8'hFF};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 15; i++) begin
			v = 8'($random(seed));
			if (i >= 5) apb(1'b1, idx[i % 5], v);
			apb(1'b0, idx[i % 5], 8'h00);
			chk("register", rd, {24'h0, i < 5 ? rt[i] : v & keep[i % 5]});
			chk("slave error", {31'h0, er}, 32'h0);
		end
		apb(1'b0, 10'h230, 8'h00);
		chk("unmapped", {er, rd[30:0]}, 32'h80000000);
		for (int k = 0; k < 16; k++) begin
			lml <= 8'($random(seed));
			ltp <= k % 4 == 0 ? TEST_NONE : k % 4 == 1 ? TEST_FIVE : 4'($random(seed));
			cpd <= k % 5 == 4;
			ext = 8'($random(seed));
			apb(1'b1, IDX_EXTRA_LANE_B, ext);
			settle();
			on = cpd ? 8'h00 : lml | (ext & 8'hFE);
			rr = 1'b1;
			for (int n = 0; n < LANES; n++) begin
				rr = rr & on[n];
				ser[n] = rr & (lml[n] | ext[0]);
				e_pat[n] = on[n] && !lml[n] && (ltp == TEST_NONE || ltp == TEST_FIVE) ? TEST_RAMP : ltp;
			end
			chk("lane clocks", {24'h0, lane_clk_en}, {24'h0, on});
			chk("serializers", {24'h0, serializer_en}, {24'h0, ser});
			chk("lane patterns", lane_pattern, e_pat);
			apb(1'b0, IDX_LANE_STATUS, 8'h00);
			chk("lane status", rd, {24'h0, on});
		end
		for (int m = 0; m < 8; m++) begin
			l64 <= m[2];
			apb(1'b1, IDX_SYNC_HEADER, 8'(m));
			apb(1'b1, IDX_GAIN_CFG, 8'(m));
			settle();
			chk("sync", {11'h0, sync_ctrl}, {11'h0, m[2] && m[1:0] != 2'h2,
				m[2] && m[1:0] == 2'h2, 19'h0});
			chk("gain boost", {31'h0, gain_boost}, {31'h0, m[0]});
		end
		ti = 8'($random(seed));
		tq = 8'($random(seed));
		apb(1'b1, IDX_THR_INPHASE, ti);
		apb(1'b1, IDX_THR_QUAD, tq);
		xi = '0;
		xq = '0;
		for (int s = 0; s < 42; s++) begin
			d = s == 0 ? 16'h8000 : s == 1 ? {1'b0, ti, 7'h0} : 16'($random(seed));
			d = s == 2 ? {1'b0, ti, 7'h0} - 16'h1 : d;
			pv = s < 3 || (s < 40 && ($random(seed) & 1));
			q = -d;
			@(posedge clk);
			ddc_i_in <= '{pv, d};
			ddc_q_in <= '{pv, q};
			#1;
			chk("inphase out", {14'h0, ddc_i_out}, {14'h0, xi});
			chk("quad out", {14'h0, ddc_q_out}, {14'h0, xq});
			xi = '{pv, tag(pv, d, ti), d};
			xq = '{pv, tag(pv, q, tq), q};
			ei += xi.ctrl;
			eq += xq.ctrl;
		end
		chk("inphase tags", i_tags, ei);
		chk("quad tags", q_tags, eq);
		apb(1'b0, IDX_IRQ_STATUS, 8'h00);
		chk("irq status", rd, 32'h3);
		irq_is(1'b0);
		apb(1'b1, IDX_IRQ_MASK, 8'h07);
		irq_is(1'b1);
		apb(1'b0, IDX_IRQ_MASK, 8'h00);
		chk("irq mask", rd, 32'h7);
		apb(1'b1, IDX_IRQ_STATUS, 8'h03);
		irq_is(1'b0);
		sle <= 1'b1;
		apb(1'b1, IDX_SYNC_HEADER, 8'h00);
		irq_is(1'b1);
		sle <= 1'b0;
		apb(1'b0, IDX_IRQ_STATUS, 8'h00);
		chk("irq status", rd, 32'h4);
		apb(1'b1, IDX_IRQ_STATUS, 8'h04);
		irq_is(1'b0);
		tally_and_finish();
	end
endmodule : tb_top
